// [core/accmp_channel.sv]
// One comparator channel: gating, polarity, latching and edge detection.
module accmp_channel import accmp_pkg::*; (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire accmp_cfg_t cfg,
  input wire logic raw_sync,
  input wire logic timer_fall,
  output logic cycle_out,
  output logic pin_out,
  output logic edge_event,
  output logic rise_pulse
);

  typedef struct packed {
    logic cycle_out;
    logic prev_out;
    logic sync_out;
    logic pin_out;
    logic edge_event;
    logic rise_pulse;
  } accmp_ch_t;

  accmp_ch_t state_q;
  accmp_ch_t state_d;
  logic adjusted;
  logic rise;
  logic fall;

  // A disabled comparator reads zero before polarity, so toggling polarity
  // still makes an edge while disabled.
  assign adjusted = (cfg.enable & raw_sync) ^ cfg.polarity_invert;

  assign rise = state_q.cycle_out & ~state_q.prev_out;
  assign fall = ~state_q.cycle_out & state_q.prev_out;

  always_comb begin
    state_d = state_q;
    if (clk_en) begin
      state_d.cycle_out = adjusted;
      state_d.prev_out = state_q.cycle_out;
      // Sync mode latches on the prescaled timer falling edge only.
      if (timer_fall) begin
        state_d.sync_out = adjusted;
      end
      state_d.pin_out = cfg.sync_mode ? state_d.sync_out : adjusted;
      state_d.edge_event = (rise & cfg.rising_edge_irq_enable)
        | (fall & cfg.falling_edge_irq_enable);
      state_d.rise_pulse = rise;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign cycle_out = state_q.cycle_out;
  assign pin_out = state_q.pin_out;
  assign edge_event = state_q.edge_event;
  assign rise_pulse = state_q.rise_pulse;

endmodule : accmp_channel

// [core/accmp_pkg.sv]
// Package with register map, field layout and select encodings.
package accmp_pkg;

  localparam int ACCMP_NUM = 3;
  localparam int ACCMP_AW = 4;

  // Register word indices; the byte address is four times the index.
  localparam logic [3:0] ACCMP_IDX_CTRL0 = 4'h0;
  localparam logic [3:0] ACCMP_IDX_CTRL1 = 4'h1;
  localparam logic [3:0] ACCMP_IDX_NSEL = 4'h2;
  localparam logic [3:0] ACCMP_IDX_PSEL = 4'h3;
  localparam logic [3:0] ACCMP_IDX_STRIDE = 4'h4;
  localparam logic [3:0] ACCMP_IDX_MIRROR = 4'hC;
  localparam logic [3:0] ACCMP_IDX_IRQ_FLAG = 4'hD;
  localparam logic [3:0] ACCMP_IDX_IRQ_EN = 4'hE;

  // Control register zero bit positions.
  localparam int ACCMP_C0_EN = 7;
  localparam int ACCMP_C0_OUT = 6;
  localparam int ACCMP_C0_POL = 4;
  localparam int ACCMP_C0_HYS = 1;
  localparam int ACCMP_C0_SYNC = 0;
  // Control register one bit positions.
  localparam int ACCMP_C1_RISE = 1;
  localparam int ACCMP_C1_FALL = 0;

  // Positive input select codes.
  localparam logic [2:0] ACCMP_PSEL_PIN0 = 3'h0;
  localparam logic [2:0] ACCMP_PSEL_PIN1 = 3'h1;
  localparam logic [2:0] ACCMP_PSEL_DAC = 3'h5;
  localparam logic [2:0] ACCMP_PSEL_REF = 3'h6;
  localparam logic [2:0] ACCMP_PSEL_GND = 3'h7;
  // Negative input select codes.
  localparam logic [2:0] ACCMP_NSEL_PIN4 = 3'h4;
  localparam logic [2:0] ACCMP_NSEL_NC = 3'h5;
  localparam logic [2:0] ACCMP_NSEL_REF = 3'h6;
  localparam logic [2:0] ACCMP_NSEL_GND = 3'h7;

  localparam logic [2:0] ACCMP_RESET_CTRL = 3'h0;

  // Per-comparator configuration.
  typedef struct packed {
    logic enable;
    logic polarity_invert;
    logic hysteresis_enable;
    logic sync_mode;
    logic rising_edge_irq_enable;
    logic falling_edge_irq_enable;
    logic [2:0] positive_input_select;
    logic [2:0] negative_input_select;
  } accmp_cfg_t;

  // One-hot analog mux enables driven to the analog front end.
  typedef struct packed {
    logic [7:0] pos_mux;
    logic [4:0] neg_pin_mux;
    logic neg_ref;
    logic neg_gnd;
  } accmp_mux_t;

  typedef enum logic [1:0] {
    ACCMP_BUS_IDLE = 2'b01,
    ACCMP_BUS_DONE = 2'b10
  } accmp_bus_state_t;

endpackage : accmp_pkg

// [core/accmp_sync2.sv]
// Two-flop synchroniser for an input from outside the clock domain.
module accmp_sync2 import accmp_pkg::*; (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic async_in,
  output logic sync_out
);

  typedef struct packed {
    logic first;
    logic second;
  } accmp_sync_t;

  accmp_sync_t state_q;
  accmp_sync_t state_d;

  // The first stage is read only by the second stage.
  always_comb begin
    state_d = state_q;
    if (clk_en) begin
      state_d.first = async_in;
      state_d.second = state_q.first;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign sync_out = state_q.second;

endmodule : accmp_sync2

// [core/accmp_top.sv]
// Three-channel analog comparator control with an Avalon-MM slave.
module accmp_top import accmp_pkg::*; (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [2:0] analog_compare,
  input wire logic timer_clk_prescaled,
  input wire logic [2:0] pin_output_select,
  input wire logic [2:0] pin_direction,
  output logic [2:0] comparator_pin,
  output logic [2:0] timer_gate,
  output logic [2:0] adc_trigger,
  output logic [2:0] comparator_irq_flag,
  output logic [2:0] comparator_irq_enable,
  output logic [2:0] hysteresis_enable,
  output accmp_mux_t [2:0] analog_mux
);

  // Whole module state.
  typedef struct packed {
    accmp_cfg_t [2:0] cfg;
    logic [2:0] irq_flag;
    logic [2:0] irq_en;
    logic [2:0] pin;
    logic [2:0] gate;
    logic [2:0] trig;
    logic [2:0] hys;
    accmp_mux_t [2:0] mux;
    logic [31:0] rdata;
    accmp_bus_state_t bus;
    logic tclk_prev;
  } accmp_state_t;

  accmp_state_t state_q;
  accmp_state_t state_d;
  logic [2:0] raw_sync;
  logic tclk_sync;
  logic timer_fall;
  logic [2:0] cycle_out;
  logic [2:0] ch_pin;
  logic [2:0] edge_event;
  logic [2:0] rise_pulse;
  logic [3:0] word;
  logic [1:0] chan;
  logic [1:0] reg_sel;
  logic in_chan;
  logic take;

  // Pins and the timer clock come from outside, so synchronise them.
  accmp_sync2 u_sync_tclk (
    .core_clk(core_clk),
    .reset(reset),
    .clk_en(clk_en),
    .async_in(timer_clk_prescaled),
    .sync_out(tclk_sync)
  );

  // Falling edge of the prescaled timer clock, seen after synchronising.
  assign timer_fall = state_q.tclk_prev & ~tclk_sync;

  genvar gi;
  generate
    for (gi = 0; gi < ACCMP_NUM; gi++) begin : g_ch
      accmp_sync2 u_sync_cmp (
        .core_clk(core_clk),
        .reset(reset),
        .clk_en(clk_en),
        .async_in(analog_compare[gi]),
        .sync_out(raw_sync[gi])
      );
      accmp_channel u_ch (
        .core_clk(core_clk),
        .reset(reset),
        .clk_en(clk_en),
        .cfg(state_q.cfg[gi]),
        .raw_sync(raw_sync[gi]),
        .timer_fall(timer_fall),
        .cycle_out(cycle_out[gi]),
        .pin_out(ch_pin[gi]),
        .edge_event(edge_event[gi]),
        .rise_pulse(rise_pulse[gi])
      );
    end
  endgenerate

  // Address decode: word index, then channel and register in a block.
  assign word = avs_address[5:2];
  assign chan = word[3:2];
  assign reg_sel = word[1:0];
  assign in_chan = (word < ACCMP_IDX_MIRROR);
  assign take = (avs_read | avs_write)
    && (state_q.bus == ACCMP_BUS_IDLE) && clk_en;

  // Read data mux for the addressed register.
  function automatic logic [31:0] read_word(input accmp_state_t s,
      input logic [2:0] cout);
    logic [31:0] r;
    accmp_cfg_t c;
    r = 32'h0000_0000;
    c = s.cfg[chan];
    if (in_chan) begin
      case (reg_sel)
        2'h0: begin
          r[ACCMP_C0_EN] = c.enable;
          r[ACCMP_C0_OUT] = cout[chan];
          r[ACCMP_C0_POL] = c.polarity_invert;
          r[ACCMP_C0_HYS] = c.hysteresis_enable;
          r[ACCMP_C0_SYNC] = c.sync_mode;
        end
        2'h1: begin
          r[ACCMP_C1_RISE] = c.rising_edge_irq_enable;
          r[ACCMP_C1_FALL] = c.falling_edge_irq_enable;
        end
        2'h2: r[2:0] = c.negative_input_select;
        default: r[2:0] = c.positive_input_select;
      endcase
    end else if (word == ACCMP_IDX_MIRROR) begin
      r[2:0] = cout;
    end else if (word == ACCMP_IDX_IRQ_FLAG) begin
      r[2:0] = s.irq_flag;
    end else if (word == ACCMP_IDX_IRQ_EN) begin
      r[2:0] = s.irq_en;
    end
    return r;
  endfunction : read_word

  // Positive mux is one-hot, with open codes and disabled giving none.
  function automatic logic [7:0] pos_mux(input accmp_cfg_t c);
    logic [7:0] m;
    m = 8'h00;
    if (c.enable) begin
      case (c.positive_input_select)
        ACCMP_PSEL_PIN0, ACCMP_PSEL_PIN1, ACCMP_PSEL_DAC,
        ACCMP_PSEL_REF, ACCMP_PSEL_GND: begin
          m[c.positive_input_select] = 1'b1;
        end
        default: m = 8'h00;
      endcase
    end
    return m;
  endfunction : pos_mux

  // Negative mux selection from the three-bit code.
  function automatic accmp_mux_t neg_mux(input accmp_cfg_t c,
      input logic [7:0] p);
    accmp_mux_t m;
    m = '0;
    m.pos_mux = p;
    if (c.enable) begin
      case (c.negative_input_select)
        ACCMP_NSEL_GND: m.neg_gnd = 1'b1;
        ACCMP_NSEL_REF: m.neg_ref = 1'b1;
        ACCMP_NSEL_NC: m.neg_pin_mux = 5'h00;
        default: begin
          m.neg_pin_mux[c.negative_input_select] = 1'b1;
        end
      endcase
    end
    return m;
  endfunction : neg_mux

  // Next-state logic: bus slave, flags and registered outputs.
  always_comb begin
    state_d = state_q;
    if (clk_en) begin
      state_d.tclk_prev = tclk_sync;
      case (state_q.bus)
        ACCMP_BUS_IDLE: begin
          if (take) begin
            state_d.bus = ACCMP_BUS_DONE;
            state_d.rdata = avs_read ? read_word(state_q, cycle_out)
              : 32'h0000_0000;
          end
        end
        ACCMP_BUS_DONE: state_d.bus = ACCMP_BUS_IDLE;
        default: state_d.bus = ACCMP_BUS_IDLE;
      endcase
      if (take && avs_write && avs_byteenable[0]) begin
        if (in_chan) begin
          case (reg_sel)
            2'h0: begin
              state_d.cfg[chan].enable = avs_writedata[ACCMP_C0_EN];
              state_d.cfg[chan].polarity_invert =
                avs_writedata[ACCMP_C0_POL];
              state_d.cfg[chan].hysteresis_enable =
                avs_writedata[ACCMP_C0_HYS];
              state_d.cfg[chan].sync_mode = avs_writedata[ACCMP_C0_SYNC];
            end
            2'h1: begin
              state_d.cfg[chan].rising_edge_irq_enable =
                avs_writedata[ACCMP_C1_RISE];
              state_d.cfg[chan].falling_edge_irq_enable =
                avs_writedata[ACCMP_C1_FALL];
            end
            2'h2: state_d.cfg[chan].negative_input_select =
              avs_writedata[2:0];
            default: state_d.cfg[chan].positive_input_select =
              avs_writedata[2:0];
          endcase
        end else if (word == ACCMP_IDX_IRQ_FLAG) begin
          // Software may only clear flags by writing zero.
          state_d.irq_flag = state_q.irq_flag & avs_writedata[2:0];
        end else if (word == ACCMP_IDX_IRQ_EN) begin
          state_d.irq_en = avs_writedata[2:0];
        end
      end
      // Set after clear so a coincident edge wins.
      state_d.irq_flag = state_d.irq_flag | edge_event;
      // Pin drives only when mapped and direction is output (low).
      state_d.pin = ch_pin & pin_output_select & ~pin_direction;
      state_d.gate = ch_pin;
      state_d.trig = rise_pulse;
      for (int i = 0; i < ACCMP_NUM; i++) begin
        state_d.hys[i] = state_d.cfg[i].hysteresis_enable;
        state_d.mux[i] = neg_mux(state_d.cfg[i], pos_mux(state_d.cfg[i]));
      end
    end
  end

  // All control resets to zero: disabled, plain polarity, no interrupts.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_q <= '0;
      state_q.bus <= ACCMP_BUS_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  assign avs_readdata = state_q.rdata;
  assign avs_waitrequest = ~(state_q.bus == ACCMP_BUS_DONE);
  assign comparator_pin = state_q.pin;
  assign timer_gate = state_q.gate;
  assign adc_trigger = state_q.trig;
  assign comparator_irq_flag = state_q.irq_flag;
  assign comparator_irq_enable = state_q.irq_en;
  assign hysteresis_enable = state_q.hys;
  assign analog_mux = state_q.mux;

endmodule : accmp_top

// [verification/accmp_afe_model.sv]
// Behavioural analog front end and prescaled timer clock for the bench.
module accmp_afe_model import accmp_pkg::*; (
  input wire logic core_clk,
  input wire accmp_mux_t [2:0] analog_mux,
  input wire logic [2:0] pos_wins,
  input wire logic timer_run,
  output logic [2:0] analog_compare,
  output logic timer_clk_prescaled
);
  timeunit 1ns;
  timeprecision 1ns;
  logic flip_q = 1'b0;
  logic [1:0] div_q = 2'h0;
  // The timer clock stands still while stopped, so no capture edge occurs.
  always_ff @(posedge core_clk) begin
    flip_q <= ~flip_q;
    if (timer_run) begin
      div_q <= div_q + 2'h1;
    end
  end
  // A channel with no input connected floats; it shows a level that changes
  // every cycle, so a design that ignores the gating cannot pass by luck.
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      analog_compare[i] = (|analog_mux[i]) ? pos_wins[i] : flip_q;
    end
  end
  // Prescaled by four while running.
  assign timer_clk_prescaled = div_q[1];
endmodule : accmp_afe_model

// [verification/accmp_top_chk.sv]
// Concurrent checks on the ports of the comparator control block.
module accmp_top_chk import accmp_pkg::*; (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic avs_waitrequest,
  input wire logic [2:0] pin_output_select,
  input wire logic [2:0] pin_direction,
  input wire logic [2:0] comparator_pin,
  input wire logic [2:0] adc_trigger,
  input wire logic [2:0] comparator_irq_flag,
  input wire logic [2:0] hysteresis_enable,
  input wire accmp_mux_t [2:0] analog_mux
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  logic [7:0] sh_q [16];
  logic take;
  // A write lands on the edge where the idle slave takes it.
  assign take = avs_write && avs_waitrequest && clk_en && avs_byteenable[0];
  always_ff @(posedge core_clk) begin
    if (reset) begin
      for (int i = 0; i < 16; i++) sh_q[i] <= 8'h00;
    end else if (take) begin
      sh_q[avs_address[5:2]] <= avs_writedata[7:0];
    end
  end
  property p_wait_one;
    (avs_read || avs_write) && avs_waitrequest && clk_en |=> !avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("late answer");
  property p_wait_short;
    !avs_waitrequest && clk_en |=> avs_waitrequest;
  endproperty
  a_wait_short: assert property (p_wait_short) else $error("long ack");
  property p_rst;
    $fell(reset) |-> comparator_irq_flag == 3'h0 && analog_mux == '0 &&
      hysteresis_enable == 3'h0 && comparator_pin == 3'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  // Each channel is checked against its shadow of the written controls.
  for (genvar c = 0; c < 3; c++) begin : g_ch
    logic [7:0] c0;
    logic [2:0] ps;
    logic [2:0] ns;
    assign c0 = sh_q[4 * c];
    assign ns = sh_q[4 * c + 2][2:0];
    assign ps = sh_q[4 * c + 3][2:0];
    property p_off;
      !c0[7] && !$past(c0[7]) |-> analog_mux[c] == '0;
    endproperty
    a_off: assert property (p_off) else $error("mux on while off");
    property p_pos;
      c0[7] && $stable({c0[7], ps}) |-> analog_mux[c].pos_mux ==
        ((ps inside {[3'h2:3'h4]}) ? 8'h00 : 8'h01 << ps);
    endproperty
    a_pos: assert property (p_pos) else $error("positive mux");
    property p_neg;
      c0[7] && $stable({c0[7], ns}) |-> {analog_mux[c].neg_pin_mux,
        analog_mux[c].neg_ref, analog_mux[c].neg_gnd} == ((ns < 3'h5) ?
        {5'h01 << ns, 2'b00} : {5'h00, ns == 3'h6, ns == 3'h7});
    endproperty
    a_neg: assert property (p_neg) else $error("negative mux");
    property p_hys;
      $stable(c0[1]) |-> hysteresis_enable[c] == c0[1];
    endproperty
    a_hys: assert property (p_hys) else $error("hysteresis");
    property p_pin;
      $past(!pin_output_select[c] || pin_direction[c]) &&
        (!pin_output_select[c] || pin_direction[c]) |-> !comparator_pin[c];
    endproperty
    a_pin: assert property (p_pin) else $error("pin driven");
    property p_pulse;
      adc_trigger[c] |=> !adc_trigger[c];
    endproperty
    a_pulse: assert property (p_pulse) else $error("trigger width");
    property p_sticky;
      comparator_irq_flag[c] && !(take && avs_address[5:2] == 4'hD &&
        !avs_writedata[c]) |=> comparator_irq_flag[c];
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag lost");
    property p_set;
      adc_trigger[c] && sh_q[4 * c + 1][1] |-> ##[0:3] comparator_irq_flag[c];
    endproperty
    a_set: assert property (p_set) else $error("flag not set");
  end
endmodule : accmp_top_chk

bind accmp_top accmp_top_chk u_accmp_top_chk (.*);

// [verification/tb.sv]
// Self-checking bench for the three-channel comparator control block.
module tb;
  import accmp_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic clk_en = 1'b1;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [2:0] analog_compare, comparator_pin, timer_gate, adc_trigger;
  logic [2:0] comparator_irq_flag, comparator_irq_enable, hysteresis_enable;
  logic [2:0] pos_wins = 3'h0, pin_output_select = 3'h0;
  logic [2:0] pin_direction = 3'h7;
  accmp_mux_t [2:0] analog_mux;
  logic timer_clk_prescaled, timer_run = 1'b0;
  logic [31:0] seed_q = 32'h297D;
  logic [7:0] exp_q [$];
  int errors = 0;
  int samples_checked = 0;
  always #5 core_clk = ~core_clk;
  accmp_top u_accmp_top (.core_clk, .reset, .clk_en, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
    .avs_waitrequest, .analog_compare, .timer_clk_prescaled,
    .pin_output_select, .pin_direction, .comparator_pin, .timer_gate,
    .adc_trigger, .comparator_irq_flag, .comparator_irq_enable,
    .hysteresis_enable, .analog_mux);
  accmp_afe_model u_accmp_afe_model (.core_clk, .analog_mux, .pos_wins,
    .timer_run, .analog_compare, .timer_clk_prescaled);
  function automatic logic [31:0] xs();
    seed_q = seed_q ^ (seed_q << 13);
    seed_q = seed_q ^ (seed_q >> 17);
    seed_q = seed_q ^ (seed_q << 5);
    return seed_q;
  endfunction : xs
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    samples_checked++;
    if (seen !== want) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, want);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick
  // One Avalon access; a read leaves its expected byte for the monitor.
  task automatic access(input logic rd, input logic [3:0] idx,
      input logic [7:0] data, input logic be);
    if (rd) exp_q.push_back(data);
    avs_read <= rd;
    avs_write <= !rd;
    avs_address <= {idx, 2'b00};
    avs_writedata <= {24'h0, data};
    avs_byteenable <= {3'h0, be};
    // Wait for the answer however long it takes; the watchdog ends a hang.
    do begin
      @(posedge core_clk);
    end while (avs_waitrequest !== 1'b0);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge core_clk);
  endtask : access
  task automatic wr(input logic [3:0] idx, input logic [7:0] d);
    access(1'b0, idx, d, 1'b1);
  endtask : wr
  task automatic rd(input logic [3:0] idx, input logic [7:0] d);
    access(1'b1, idx, d, 1'b1);
  endtask : rd
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : results
  // Each completed read is matched against the oldest expectation.
  always @(posedge core_clk) begin
    if (avs_read && !avs_waitrequest) begin
      check(avs_readdata[7:0], exp_q.pop_front());
    end
  end
  // The tests take about seven hundred cycles; a hang is cut off well beyond.
  initial begin
    #200000;
    errors++;
    results();
  end
  initial begin
    logic [7:0] cfg;
    logic [2:0] want;
    logic [31:0] r;
    logic [2:0] seen;
    tick(16);
    reset <= 1'b0;
    tick(1);
    for (int i = 0; i < 16; i++) rd(i[3:0], 8'h00);
    wr(4'hF, 8'hFF);
    rd(4'hF, 8'h00);
    for (int c = 0; c < 3; c++) begin
      wr(4'(4 * c + 1), 8'hFF);
      access(1'b0, 4'(4 * c + 1), 8'h00, 1'b0);
      rd(4'(4 * c + 1), 8'h03);
      wr(4'(4 * c), 8'h80);
    end
    // Walk every input code on all channels, ending on the pin codes.
    for (int k = 7; k >= 0; k--) begin
      for (int c = 0; c < 3; c++) begin
        wr(4'(4 * c + 2), 8'(k));
        wr(4'(4 * c + 3), 8'(k));
      end
      rd(4'h3, 8'(k));
    end
    $display("registers done");
    // Enable and polarity table with random analog results.
    for (int m = 0; m < 4; m++) begin
      r = xs();
      pos_wins <= r[2:0];
      cfg = {m[1], 2'b00, m[0], 4'h0};
      for (int c = 0; c < 3; c++) wr(4'(4 * c), cfg);
      tick(6);
      want = (m[1] ? pos_wins : 3'h0) ^ {3{m[0]}};
      rd(4'hC, {5'h00, want});
      for (int c = 0; c < 3; c++) rd(4'(4 * c), cfg | {want[c], 6'h00});
    end
    $display("output done");
    wr(4'hE, 8'h07);
    check(8'(comparator_irq_enable), 8'h07);
    // Edge selects: none, falling only, rising only; edges while disabled.
    for (int m = 0; m < 3; m++) begin
      for (int c = 0; c < 3; c++) begin
        wr(4'(4 * c), 8'h00);
        wr(4'(4 * c + 1), 8'(m));
      end
      tick(4);
      wr(4'hD, 8'h00);
      for (int c = 0; c < 3; c++) wr(4'(4 * c), 8'h10);
      tick(4);
      rd(4'hD, m[1] ? 8'h07 : 8'h00);
      wr(4'hD, 8'h07);
      rd(4'hD, m[1] ? 8'h07 : 8'h00);
      wr(4'hD, 8'h00);
      for (int c = 0; c < 3; c++) wr(4'(4 * c), 8'h00);
      tick(4);
      rd(4'hD, m[0] ? 8'h07 : 8'h00);
    end
    $display("interrupts done");
    for (int c = 0; c < 3; c++) wr(4'(4 * c), 8'h82);
    check(8'(hysteresis_enable), 8'h07);
    for (int m = 0; m < 4; m++) begin
      r = xs();
      pos_wins <= r[2:0];
      pin_output_select <= r[5:3];
      pin_direction <= r[8:6];
      tick(6);
      want = pos_wins & pin_output_select & ~pin_direction;
      check(8'(comparator_pin), 8'(want));
      check(8'(timer_gate), 8'(pos_wins));
    end
    // A low clock enable freezes the whole path, synchronisers included.
    want = pos_wins;
    clk_en <= 1'b0;
    pos_wins <= ~pos_wins;
    tick(8);
    check(8'(timer_gate), 8'(want));
    clk_en <= 1'b1;
    seen = 3'h0;
    // The trigger is a one-cycle pulse, so gather it edge by edge.
    repeat (8) begin
      @(posedge core_clk);
      seen = seen | adc_trigger;
    end
    check(8'(seen), {5'h00, ~want});
    check(8'(timer_gate), {5'h00, ~want});
    // Sync mode holds the output until the timer clock falls.
    for (int c = 0; c < 3; c++) wr(4'(4 * c), 8'h81);
    timer_run <= 1'b1;
    tick(20);
    timer_run <= 1'b0;
    // The last timer fall is still in the synchroniser; let it be captured
    // before the input moves, or it would latch the new level.
    tick(4);
    want = pos_wins;
    pos_wins <= ~pos_wins;
    tick(10);
    check(8'(timer_gate), 8'(want));
    timer_run <= 1'b1;
    tick(20);
    timer_run <= 1'b0;
    tick(6);
    check(8'(timer_gate), {5'h00, ~want});
    $display("pins done");
    reset <= 1'b1;
    tick(3);
    reset <= 1'b0;
    tick(1);
    rd(4'h0, 8'h00);
    $display("second reset done");
    results();
  end
endmodule : tb
